// file: rtl/acd_pkg.sv
/*
 * Shared constants and types for the converter command decoder and its
 * calibration and result register bank.
 * Assumes nothing beyond a SystemVerilog compiler; no module lives here.
 */
`default_nettype none

package acd_pkg;

  // ==========================================================================
  // Command opcodes
  localparam logic [7:0] OP_READ      = 8'h01;
  localparam logic [7:0] OP_CONT      = 8'h03;
  localparam logic [7:0] OP_STOP      = 8'h0F;
  localparam logic [7:0] OP_SELF_CAL  = 8'hF0;
  localparam logic [7:0] OP_SELF_OFS  = 8'hF1;
  localparam logic [7:0] OP_SELF_GAIN = 8'hF2;
  localparam logic [7:0] OP_SYS_OFS   = 8'hF3;
  localparam logic [7:0] OP_SYS_GAIN  = 8'hF4;
  localparam logic [7:0] OP_WAKE      = 8'hFB;
  localparam logic [7:0] OP_SYNC      = 8'hFC;
  localparam logic [7:0] OP_SLEEP     = 8'hFD;
  localparam logic [7:0] OP_RESET     = 8'hFE;
  localparam logic [3:0] NIB_RD_REG   = 4'h1;
  localparam logic [3:0] NIB_WR_REG   = 4'h5;

  // ==========================================================================
  // Register map
  localparam logic [3:0] ADDR_CTRL     = 4'h2;
  localparam logic [3:0] ADDR_OFS_LOW  = 4'h7;
  localparam logic [3:0] ADDR_OFS_MID  = 4'h8;
  localparam logic [3:0] ADDR_OFS_HIGH = 4'h9;
  localparam logic [3:0] ADDR_FS_LOW   = 4'hA;
  localparam logic [3:0] ADDR_FS_MID   = 4'hB;
  localparam logic [3:0] ADDR_FS_HIGH  = 4'hC;
  localparam logic [3:0] ADDR_RES_HIGH = 4'hD;
  localparam logic [3:0] ADDR_RES_MID  = 4'hE;
  localparam logic [3:0] ADDR_RES_LOW  = 4'hF;
  localparam logic [3:0] RES_READ_CNT  = 4'h2;

  localparam int unsigned CTRL_READY_BIT = 7;
  localparam int unsigned CTRL_ORDER_BIT = 3;

  localparam logic [7:0]  OFS_LOW_RST  = 8'h00;
  localparam logic [7:0]  OFS_MID_RST  = 8'h00;
  localparam logic [7:0]  OFS_HIGH_RST = 8'h00;
  localparam logic [7:0]  FS_LOW_RST   = 8'h59;
  localparam logic [7:0]  FS_HIGH_RST  = 8'h55;
  localparam logic [23:0] RESULT_RST   = 24'h000000;

  localparam logic [2:0] LAST_BIT = 3'h7;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    CAL_SELF_BOTH = 3'h0,
    CAL_SELF_OFS  = 3'h1,
    CAL_SELF_GAIN = 3'h2,
    CAL_SYS_OFS   = 3'h3,
    CAL_SYS_GAIN  = 3'h4
  } acd_cal_kind_t;

  typedef struct packed {
    logic          start;
    acd_cal_kind_t kind;
  } acd_cal_req_t;

  typedef struct packed {
    logic [23:0] offset;
    logic [23:0] gain;
  } acd_coef_t;

endpackage

`default_nettype wire

// file: rtl/acd_decoder.sv
/*
 * Serial command decoder with offset, full-scale and result registers.
 * Assumes the serial pins come from outside the sys_clk domain, and that
 * the converter datapath runs on sys_clk and hands over results and
 * calibration coefficients with single-cycle strobes.
 */
// Contract
// - Opcode 01h returns the latest conversion result, no further command bytes.
// - Opcode 03h enters continuous mode; each new result is shifted out.
// - Opcode 0Fh leaves continuous mode and restores normal decoding.
// - Read command 1r then count byte; low nibble is registers minus one.
// - Write command 5r, count byte, then data into successive registers.
// - Register operand addresses 0 to 15; count taken as unsigned.
// - Opcode F0h runs offset and gain self-calibration, updating both sets.
// - F1h offset-only, F2h gain-only self-calibration; each updates its set.
// - F3h system offset, F4h system gain calibration from external input.
// - FDh enters sleep; FBh wakes and resumes normal operation.
// - FCh resynchronises conversion and data-ready timing to the command.
// - FEh returns all registers and state to power-up values.
// - Decoder tells single-byte opcodes from multi-byte; writes collect data.
// - Register 08h is offset coefficient bits 15..8, reset 00h.
// - Register 09h is offset coefficient bits 23..16, reset 00h.
// - Register 0Ah is full-scale bits 7..0, reset 59h.
// - Register 0Ch is full-scale bits 23..16; bits 15..8 the middle one.
// - Result held in three read-only bytes, middle at 0Eh; writes ignored.
// - Incoming bytes MSB first; outgoing order follows the bit-order setting.
// - Bit-order clear sends MSB first, set sends LSB first.
// - A read-only status bit mirrors the data-ready output pin.
// - The read command returns the full 24-bit result register.
`timescale 1ns/1ns
`default_nettype none

module acd_decoder #(
  parameter logic [7:0] FS_MID_RST = 8'h55
) (
  input  wire logic                  sys_clk,      // System clock.
  input  wire logic                  rst,          // Synchronous reset.
  input  wire logic                  sclk,         // Serial clock pin.
  input  wire logic                  cs_n,         // Chip select pin.
  input  wire logic                  din,          // Serial data in pin.
  output logic                       dout,         // Serial data out pin.
  output logic                       dout_en,      // Drive enable for dout.
  output logic                       data_ready_n, // Data-ready pin.
  input  wire logic                  conv_valid,   // New result strobe.
  input  wire logic [23:0]           conv_data,    // New result value.
  output acd_pkg::acd_cal_req_t      cal_req,      // Calibration start.
  input  wire logic                  cal_done,     // Calibration finished.
  input  wire acd_pkg::acd_coef_t    cal_result,   // Calibrated values.
  output acd_pkg::acd_coef_t         coef,         // Coefficients in use.
  output logic                       sleep,        // Low-power request.
  output logic                       sync_pulse    // Conversion restart.
);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_COUNT = 4'b0010,
    ST_WDATA = 4'b0100,
    ST_SEND  = 4'b1000
  } acd_state_t;

  // ==========================================================================
  // Pin synchronisers
  logic [1:0] sclk_sync_q, din_sync_q, cs_sync_q;
  logic       sclk_last_q;
  logic       sclk_rise, sclk_fall, sel;

  always_ff @(posedge sys_clk) begin
    sclk_sync_q <= {sclk_sync_q[0], sclk};
    din_sync_q  <= {din_sync_q[0], din};
    cs_sync_q   <= {cs_sync_q[0], cs_n};
    sclk_last_q <= sclk_sync_q[1];
  end

  assign sel       = !cs_sync_q[1];
  assign sclk_rise = sel && sclk_sync_q[1] && !sclk_last_q;
  assign sclk_fall = sel && !sclk_sync_q[1] && sclk_last_q;

  // ==========================================================================
  // Declarations
  acd_state_t  state_q;
  logic        clr, soft_rst_q;
  logic [2:0]  rx_cnt_q;
  logic [7:0]  rx_sh_q, rx_byte_q;
  logic        rx_strobe_q, rx_take;
  logic [7:0]  skip_q;
  logic [3:0]  addr_q, cnt_q;
  logic        is_wr_q, cont_q, cont_pend_q, cal_busy_q;
  logic        bit_order_q;
  acd_pkg::acd_cal_kind_t cal_kind_q;
  logic [23:0] ofs_q, fs_q, result_q;
  logic        push_valid, push_ready, pop_valid, pop_ready;
  logic [7:0]  fifo_q [2];
  logic        wr_ptr_q, rd_ptr_q;
  logic [1:0]  fill_q;
  logic [7:0]  tx_sh_q;
  logic [2:0]  tx_cnt_q;
  logic        idle_cmd, cal_cmd, read_cmd;
  logic        wr_en;

  assign clr = rst || soft_rst_q;

  // ==========================================================================
  // Functions
  function automatic logic [7:0] bit_rev(input logic [7:0] b);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7 - i];
    end
    return r;
  endfunction

  function automatic logic [7:0] reg_rd(input logic [3:0] a);
    logic [7:0] v;
    v = '0;
    unique case (a)
      acd_pkg::ADDR_CTRL: begin
        v[acd_pkg::CTRL_READY_BIT] = data_ready_n;
        v[acd_pkg::CTRL_ORDER_BIT] = bit_order_q;
      end
      acd_pkg::ADDR_OFS_LOW:  v = ofs_q[7:0];
      acd_pkg::ADDR_OFS_MID:  v = ofs_q[15:8];
      acd_pkg::ADDR_OFS_HIGH: v = ofs_q[23:16];
      acd_pkg::ADDR_FS_LOW:   v = fs_q[7:0];
      acd_pkg::ADDR_FS_MID:   v = fs_q[15:8];
      acd_pkg::ADDR_FS_HIGH:  v = fs_q[23:16];
      acd_pkg::ADDR_RES_HIGH: v = result_q[23:16];
      acd_pkg::ADDR_RES_MID:  v = result_q[15:8];
      acd_pkg::ADDR_RES_LOW:  v = result_q[7:0];
      default:                v = '0;
    endcase
    return v;
  endfunction

  // ==========================================================================
  // Receive shifter
  // Bytes are assembled MSB first regardless of the output bit order.
  always_ff @(posedge sys_clk) begin
    rx_strobe_q <= 1'b0;
    if (clr || !sel) begin
      rx_cnt_q <= '0;
      rx_sh_q  <= '0;
    end else if (sclk_fall) begin
      rx_sh_q  <= {rx_sh_q[6:0], din_sync_q[1]};
      rx_cnt_q <= rx_cnt_q + 3'h1;
      if (rx_cnt_q == acd_pkg::LAST_BIT) begin
        rx_byte_q   <= {rx_sh_q[6:0], din_sync_q[1]};
        rx_strobe_q <= 1'b1;
      end
    end
  end

  // Bytes that arrive while reply bytes go out are don't-care filler.
  // In continuous mode they are still decoded so that a stop is seen.
  assign rx_take = rx_strobe_q && (cont_q || skip_q == '0);

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      skip_q <= '0;
    end else begin
      skip_q <= skip_q
              + 8'((push_valid && push_ready && !cont_q) ? 1 : 0)
              - 8'((rx_strobe_q && skip_q != '0) ? 1 : 0);
    end
  end

  // ==========================================================================
  // Command decoding
  assign idle_cmd = rx_take && state_q == ST_IDLE && !cont_q;
  assign cal_cmd  = idle_cmd && rx_byte_q >= acd_pkg::OP_SELF_CAL
                 && rx_byte_q <= acd_pkg::OP_SYS_GAIN;
  assign read_cmd = idle_cmd && rx_byte_q == acd_pkg::OP_READ;
  assign wr_en    = rx_take && state_q == ST_WDATA;

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      state_q     <= ST_IDLE;
      addr_q      <= '0;
      cnt_q       <= '0;
      is_wr_q     <= 1'b0;
      cont_pend_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (read_cmd) begin
            addr_q  <= acd_pkg::ADDR_RES_HIGH;
            cnt_q   <= acd_pkg::RES_READ_CNT;
            state_q <= ST_SEND;
          end else if (idle_cmd && (rx_byte_q[7:4] == acd_pkg::NIB_RD_REG
                       || rx_byte_q[7:4] == acd_pkg::NIB_WR_REG)) begin
            addr_q  <= rx_byte_q[3:0];
            is_wr_q <= rx_byte_q[7:4] == acd_pkg::NIB_WR_REG;
            state_q <= ST_COUNT;
          end else if (cont_q && cont_pend_q) begin
            addr_q      <= acd_pkg::ADDR_RES_HIGH;
            cnt_q       <= acd_pkg::RES_READ_CNT;
            cont_pend_q <= 1'b0;
            state_q     <= ST_SEND;
          end
        end
        ST_COUNT: begin
          if (rx_take) begin
            cnt_q   <= rx_byte_q[3:0];
            state_q <= is_wr_q ? ST_WDATA : ST_SEND;
          end
        end
        ST_WDATA: begin
          if (rx_take) begin
            addr_q <= addr_q + 4'h1;
            cnt_q  <= cnt_q - 4'h1;
            if (cnt_q == '0) begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_SEND: begin
          if (push_ready) begin
            addr_q <= addr_q + 4'h1;
            cnt_q  <= cnt_q - 4'h1;
            if (cnt_q == '0) begin
              state_q <= ST_IDLE;
            end
          end
        end
      endcase
      // A result arriving as the pending one is taken stays pending.
      if (conv_valid && cont_q) begin
        cont_pend_q <= 1'b1;
      end
    end
  end

  // Modes; any opcode not matched here falls through untouched.
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      cont_q <= 1'b0;
      sleep  <= 1'b0;
    end else if (rx_take && state_q == ST_IDLE) begin
      if (cont_q) begin
        if (rx_byte_q == acd_pkg::OP_STOP) begin
          cont_q <= 1'b0;
        end
      end else if (rx_byte_q == acd_pkg::OP_CONT) begin
        cont_q <= 1'b1;
      end else if (rx_byte_q == acd_pkg::OP_SLEEP) begin
        sleep <= 1'b1;
      end else if (rx_byte_q == acd_pkg::OP_WAKE) begin
        sleep <= 1'b0;
      end
    end
  end

  // Soft reset takes effect one cycle later and clears all control state except dout_en.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= idle_cmd && rx_byte_q == acd_pkg::OP_RESET;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      sync_pulse <= 1'b0;
    end else begin
      sync_pulse <= idle_cmd && rx_byte_q == acd_pkg::OP_SYNC;
    end
  end

  // ==========================================================================
  // Calibration
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      cal_busy_q    <= 1'b0;
      cal_kind_q    <= acd_pkg::CAL_SELF_BOTH;
      cal_req.start <= 1'b0;
      cal_req.kind  <= acd_pkg::CAL_SELF_BOTH;
    end else begin
      cal_req.start <= cal_cmd && !cal_busy_q;
      if (cal_cmd && !cal_busy_q) begin
        cal_busy_q   <= 1'b1;
        cal_kind_q   <= acd_pkg::acd_cal_kind_t'(rx_byte_q[2:0]);
        cal_req.kind <= acd_pkg::acd_cal_kind_t'(rx_byte_q[2:0]);
      end else if (cal_done) begin
        cal_busy_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Register bank
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      ofs_q       <= {acd_pkg::OFS_HIGH_RST, acd_pkg::OFS_MID_RST,
                      acd_pkg::OFS_LOW_RST};
      fs_q        <= {acd_pkg::FS_HIGH_RST, FS_MID_RST,
                      acd_pkg::FS_LOW_RST};
      result_q    <= acd_pkg::RESULT_RST;
      bit_order_q <= 1'b0;
    end else begin
      if (conv_valid) begin
        result_q <= conv_data;
      end
      if (cal_done && cal_busy_q) begin
        if (cal_kind_q != acd_pkg::CAL_SELF_GAIN
            && cal_kind_q != acd_pkg::CAL_SYS_GAIN) begin
          ofs_q <= cal_result.offset;
        end
        if (cal_kind_q != acd_pkg::CAL_SELF_OFS
            && cal_kind_q != acd_pkg::CAL_SYS_OFS) begin
          fs_q <= cal_result.gain;
        end
      end else if (wr_en) begin
        unique case (addr_q)
          acd_pkg::ADDR_CTRL:
            bit_order_q <= rx_byte_q[acd_pkg::CTRL_ORDER_BIT];
          acd_pkg::ADDR_OFS_LOW:  ofs_q[7:0]   <= rx_byte_q;
          acd_pkg::ADDR_OFS_MID:  ofs_q[15:8]  <= rx_byte_q;
          acd_pkg::ADDR_OFS_HIGH: ofs_q[23:16] <= rx_byte_q;
          acd_pkg::ADDR_FS_LOW:   fs_q[7:0]    <= rx_byte_q;
          acd_pkg::ADDR_FS_MID:   fs_q[15:8]   <= rx_byte_q;
          acd_pkg::ADDR_FS_HIGH:  fs_q[23:16]  <= rx_byte_q;
          default: ;
        endcase
      end
    end
  end

  assign coef = '{offset: ofs_q, gain: fs_q};

  // A new result wins over a read or sync clearing event in the same cycle; a calibration command wins over it.
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      data_ready_n <= 1'b1;
    end else if (conv_valid && !cal_busy_q && !cal_cmd) begin
      data_ready_n <= 1'b0;
    end else if (cal_done && cal_busy_q) begin
      data_ready_n <= 1'b0;
    end else if (cal_cmd || read_cmd || sync_pulse) begin
      data_ready_n <= 1'b1;
    end
  end

  // ==========================================================================
  // Two-entry reply buffer
  // The decoder stalls while both entries hold bytes the host has not
  // clocked out yet, so long register reads never drop a byte.
  assign push_valid = state_q == ST_SEND;
  assign push_ready = fill_q != 2'h2;
  assign pop_valid  = fill_q != 2'h0;
  assign pop_ready  = sclk_rise && tx_cnt_q == '0 && rx_cnt_q == '0;

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      fill_q   <= '0;
    end else begin
      if (push_valid && push_ready) begin
        fifo_q[wr_ptr_q] <= reg_rd(addr_q);
        wr_ptr_q         <= !wr_ptr_q;
      end
      if (pop_valid && pop_ready) begin
        rd_ptr_q <= !rd_ptr_q;
      end
      fill_q <= fill_q + 2'((push_valid && push_ready) ? 1 : 0)
                       - 2'((pop_valid && pop_ready) ? 1 : 0);
    end
  end

  // ==========================================================================
  // Transmit shifter
  // Bytes only start on a byte boundary so output stays aligned to input.
  always_ff @(posedge sys_clk) begin
    if (clr || !sel) begin
      tx_sh_q  <= '0;
      tx_cnt_q <= '0;
      dout     <= 1'b0;
    end else if (sclk_rise) begin
      if (tx_cnt_q == '0 && rx_cnt_q == '0 && pop_valid) begin
        if (bit_order_q) begin
          dout    <= fifo_q[rd_ptr_q][0];
          tx_sh_q <= bit_rev(fifo_q[rd_ptr_q]) << 1;
        end else begin
          dout    <= fifo_q[rd_ptr_q][7];
          tx_sh_q <= {fifo_q[rd_ptr_q][6:0], 1'b0};
        end
        tx_cnt_q <= acd_pkg::LAST_BIT;
      end else if (tx_cnt_q != '0) begin
        dout     <= tx_sh_q[7];
        tx_sh_q  <= {tx_sh_q[6:0], 1'b0};
        tx_cnt_q <= tx_cnt_q - 3'h1;
      end else begin
        dout <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dout_en <= 1'b0;
    end else begin
      dout_en <= sel;
    end
  end

endmodule

`default_nettype wire

// file: verif/acd_decoder_sva.sv
/*
 * Checker for the command decoder, bound to its ports.
 * Assumes one clock domain, sys_clk, with synchronous active-high rst.
 */
`timescale 1ns/1ns
`default_nettype none

module acd_decoder_sva (
  input wire logic                  sys_clk,      // System clock.
  input wire logic                  rst,          // Synchronous reset.
  input wire logic                  cs_n,         // Chip select pin.
  input wire logic                  dout_en,      // Drive enable for dout.
  input wire logic                  data_ready_n, // Data-ready pin.
  input wire logic                  conv_valid,   // New result strobe.
  input wire acd_pkg::acd_cal_req_t cal_req,      // Calibration start.
  input wire logic                  cal_done,     // Calibration finished.
  input wire acd_pkg::acd_coef_t    cal_result,   // Calibrated values.
  input wire acd_pkg::acd_coef_t    coef,         // Coefficients in use.
  input wire logic                  sleep,        // Low-power request.
  input wire logic                  sync_pulse    // Conversion restart.
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Calibration tracking
  // The kind is latched at start because the request may change later.
  logic                   cal_busy_q;
  acd_pkg::acd_cal_kind_t kind_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cal_busy_q <= 1'b0;
    end else if (cal_req.start) begin
      cal_busy_q <= 1'b1;
    end else if (cal_done) begin
      cal_busy_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (cal_req.start) begin
      kind_q <= cal_req.kind;
    end
  end

  sequence cal_end_s;
    cal_busy_q && cal_done;
  endsequence

  // ==========================================================================
  // Assertions
  reset_out_a: assert property ($fell(rst) |-> data_ready_n && !sleep
    && !cal_req.start && !sync_pulse && !dout_en && coef.offset == 24'h0)
    else $error("outputs not idle after reset");
  cs_idle_a: assert property (cs_n [*4] |-> !dout_en)
    else $error("dout driven while deselected");
  // Busy here lags the decoder by one cycle; the start pulse covers the gap.
  conv_ready_a: assert property (conv_valid && !cal_busy_q
    && !cal_req.start |=> !data_ready_n || cal_req.start)
    else $error("data ready missing after result");
  cal_quiet_a: assert property (cal_busy_q |-> data_ready_n)
    else $error("data ready active during calibration");
  cal_ready_a: assert property (cal_end_s |=> !data_ready_n)
    else $error("data ready missing after calibration");
  cal_both_a: assert property (cal_end_s ##0
    kind_q == acd_pkg::CAL_SELF_BOTH |=> coef == $past(cal_result))
    else $error("full calibration not loaded");
  ofs_only_a: assert property (cal_end_s ##0
    (kind_q inside {acd_pkg::CAL_SELF_OFS, acd_pkg::CAL_SYS_OFS}) |=>
    coef.offset == $past(cal_result.offset) && $stable(coef.gain))
    else $error("offset calibration load wrong");
  gain_only_a: assert property (cal_end_s ##0
    (kind_q inside {acd_pkg::CAL_SELF_GAIN, acd_pkg::CAL_SYS_GAIN}) |=>
    coef.gain == $past(cal_result.gain) && $stable(coef.offset))
    else $error("gain calibration load wrong");
  start_pulse_a: assert property (cal_req.start |=> !cal_req.start)
    else $error("calibration start longer than one cycle");
  sync_once_a: assert property (sync_pulse |=> !sync_pulse)
    else $error("sync pulse longer than one cycle");
endmodule

bind acd_decoder acd_decoder_sva acd_decoder_sva_i (
  .sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .dout_en(dout_en),
  .data_ready_n(data_ready_n), .conv_valid(conv_valid), .cal_req(cal_req),
  .cal_done(cal_done), .cal_result(cal_result), .coef(coef),
  .sleep(sleep), .sync_pulse(sync_pulse));

`default_nettype wire

// file: verif/acd_host.sv
/*
 * Host controller model on the serial port of the decoder.
 * Assumes the bench calls its tasks; the link clock is 160 ns and stands
 * still low outside bytes, with its edges kept 3 ns off the system clock.
 */
`timescale 1ns/1ns
`default_nettype none

module acd_host (
  output var logic       sclk,    // Serial clock to the device.
  output var logic       cs_n,    // Chip select to the device.
  output var logic       din,     // Serial data to the device.
  input wire logic       dout,    // Serial data from the device.
  output var logic       rx_stb,  // Pulse when a captured byte is ready.
  output var logic [7:0] rx_byte  // Last captured byte.
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
  end

  // Bytes go out most significant bit first, changed on the rising edge
  // and held over the falling edge where the device samples them.
  task automatic xfer(input logic [7:0] tx, input logic cap);
    logic [7:0] rx;
    rx = 8'h00;
    if (cs_n) begin
      #(203 - ($time % 10));
      cs_n = 1'b0;
    end
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b1;
      din = tx[i];
      #80;
      sclk = 1'b0;
      rx = {rx[6:0], dout};
      #80;
    end
    // The capture pulse takes 1 ns, so the byte still ends 3 ns off the clock.
    #(cap ? 119 : 120);
    if (cap) begin
      rx_byte = rx;
      rx_stb = 1'b1;
      #1;
      rx_stb = 1'b0;
    end
  endtask

  // A released data line shows the inverse, never a stale copy.
  task automatic release_bus();
    #200;
    cs_n = 1'b1;
    din = ~din;
    #300;
  endtask
endmodule

`default_nettype wire

// file: verif/acd_decoder_tb.sv
/*
 * Self-checking bench for the command decoder and its register bank.
 * Assumes the host model and the bound checker are compiled before it.
 */
`timescale 1ns/1ns
`default_nettype none

module acd_decoder_tb;
  logic               sys_clk = 1'b0;
  logic               rst = 1'b1;
  logic               conv_valid = 1'b0;
  logic               cal_done = 1'b0;
  logic [23:0]        conv_data = 24'h000000;
  acd_pkg::acd_coef_t cal_result = '0;
  acd_pkg::acd_coef_t coef;
  acd_pkg::acd_cal_req_t cal_req;
  wire logic          sclk, cs_n, din, dout, dout_en, data_ready_n;
  wire logic          sleep, sync_pulse, rx_stb;
  wire logic [7:0]    rx_byte;
  logic [7:0]         exp_q[$];
  int                 error_cnt = 0;
  int                 checks = 0;
  int                 starts = 0;
  int                 syncs = 0;
  logic [2:0]         kind_seen = 3'h0;
  logic [31:0]        rnd = 32'h207E;

  always #5 sys_clk = ~sys_clk;

  acd_decoder acd_decoder_i (.sys_clk(sys_clk), .rst(rst), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout(dout), .dout_en(dout_en),
    .data_ready_n(data_ready_n), .conv_valid(conv_valid),
    .conv_data(conv_data), .cal_req(cal_req), .cal_done(cal_done),
    .cal_result(cal_result), .coef(coef), .sleep(sleep),
    .sync_pulse(sync_pulse));
  // An undriven data line shows the inverse, so a late enable corrupts bytes.
  acd_host acd_host_i (.sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout_en ? dout : !dout), .rx_stb(rx_stb), .rx_byte(rx_byte));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev8[i] = b[7 - i];
  endfunction

  task automatic chk(input logic [47:0] exp, input logic [47:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Replies are compared as the host captures them, oldest note first.
  always @(posedge rx_stb) begin
    if (exp_q.size() == 0) chk(48'h0, 48'h1);
    else chk(48'(exp_q.pop_front()), 48'(rx_byte));
  end

  always @(posedge sys_clk) begin
    if (cal_req.start) begin
      starts++;
      kind_seen = cal_req.kind;
    end
    if (sync_pulse) syncs++;
  end

  task automatic cmd(input logic [7:0] op);
    acd_host_i.xfer(op, 1'b0);
  endtask

  task automatic op1(input logic [7:0] op);
    cmd(op);
    acd_host_i.release_bus();
  endtask

  task automatic register_read_cmd(input logic [3:0] r, input logic [3:0] n);
    cmd({4'h1, r});
    cmd({4'h0, n});
    repeat (int'(n) + 1) acd_host_i.xfer(8'h00, 1'b1);
    acd_host_i.release_bus();
  endtask

  task automatic register_write_cmd(input logic [3:0] r, input logic [7:0] d);
    cmd({4'h5, r});
    cmd(8'h00);
    op1(d);
  endtask

  task automatic rdata();
    cmd(8'h01);
    repeat (3) acd_host_i.xfer(8'h00, 1'b1);
    acd_host_i.release_bus();
  endtask

  task automatic new_result(output logic [23:0] v);
    rnd = lfsr(rnd);
    v = rnd[23:0];
    @(posedge sys_clk);
    conv_valid <= 1'b1;
    conv_data <= v;
    @(posedge sys_clk);
    conv_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    error_cnt++;
    wrap_up();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [23:0] v;
    logic [47:0] c;
    int          n;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(48'(coef), {24'h0, 24'h555559});
    exp_q = '{8'h00, 8'h00, 8'h00, 8'h59, 8'h55, 8'h55};
    register_read_cmd(4'h7, 4'h5);
    cmd(8'h58);
    cmd(8'h01);
    cmd(8'hAB);
    op1(8'hCD);
    chk(48'(coef.offset[23:8]), 48'hCDAB);
    $display("test registers done");
    new_result(v);
    register_write_cmd(4'hE, 8'h77);
    exp_q = '{v[23:16], v[15:8], v[7:0], 8'h00, 8'h00};
    register_read_cmd(4'hD, 4'h3);
    register_read_cmd(4'h2, 4'h0);
    exp_q = '{v[23:16], v[15:8], v[7:0], 8'h80};
    rdata();
    register_read_cmd(4'h2, 4'h0);
    register_write_cmd(4'h2, 8'h08);
    new_result(v);
    exp_q = '{rev8(v[23:16]), rev8(v[15:8]), rev8(v[7:0])};
    rdata();
    register_write_cmd(4'h2, 8'h00);
    $display("test reads done");
    cmd(8'h03);
    repeat (2) begin
      new_result(v);
      exp_q = '{v[23:16], v[15:8], v[7:0]};
      repeat (3) acd_host_i.xfer(8'h00, 1'b1);
    end
    op1(8'h0F);
    new_result(v);
    exp_q = '{v[23:16], v[15:8], v[7:0]};
    rdata();
    $display("test continuous done");
    for (int k = 0; k < 5; k++) begin
      n = starts;
      op1(8'hF0 + 8'(k));
      chk(48'(starts), 48'(n + 1));
      chk(48'(kind_seen), 48'(k));
      chk(48'(data_ready_n), 48'h1);
      c = coef;
      rnd = lfsr(rnd);
      @(posedge sys_clk);
      cal_result <= {rnd[23:0], rnd[31:8]};
      cal_done <= 1'b1;
      @(posedge sys_clk);
      cal_done <= 1'b0;
      repeat (2) @(posedge sys_clk);
      if (k != 2 && k != 4) c[47:24] = cal_result.offset;
      if (k != 1 && k != 3) c[23:0] = cal_result.gain;
      chk(48'(coef), c);
      chk(48'(data_ready_n), 48'h0);
    end
    $display("test calibration done");
    op1(8'hFD);
    chk(48'(sleep), 48'h1);
    c = coef;
    cmd(8'h77);
    op1(8'hF8);
    chk(48'(coef), c);
    chk(48'(sleep), 48'h1);
    op1(8'hFB);
    chk(48'(sleep), 48'h0);
    n = syncs;
    op1(8'hFC);
    chk(48'(syncs), 48'(n + 1));
    op1(8'hFE);
    chk(48'(coef), {24'h0, 24'h555559});
    exp_q = '{8'h59};
    register_read_cmd(4'hA, 4'h0);
    chk(48'(exp_q.size()), 48'h0);
    $display("test modes done");
    wrap_up();
  end
endmodule

`default_nettype wire
